// ### shared/lswe_pkg.sv
package lswe_pkg;

  // ---------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ          = 20_000_000;
  localparam int CNT_W           = 27;
  localparam int IDLE_TIMEOUT_MS = 4000;
  localparam int WAKE_RESP_MS    = 150;
  localparam int WAKE_PULSE_US   = 1000;
  localparam int WAKE_DETECT_US  = 150;

  localparam logic [CNT_W-1:0] IDLE_CYCLES =
    CNT_W'(CLK_HZ / 1000 * IDLE_TIMEOUT_MS);
  localparam logic [CNT_W-1:0] RESP_CYCLES =
    CNT_W'(CLK_HZ / 1000 * WAKE_RESP_MS);
  localparam logic [CNT_W-1:0] PULSE_CYCLES =
    CNT_W'(CLK_HZ / 1_000_000 * WAKE_PULSE_US);
  localparam logic [CNT_W-1:0] DETECT_CYCLES =
    CNT_W'(CLK_HZ / 1_000_000 * WAKE_DETECT_US);

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam int          ADDR_W    = 2;
  localparam int          DATA_W    = 8;
  localparam logic [1:0]  ADDR_CTRL = 2'h0;
  localparam logic [1:0]  ADDR_STAT = 2'h1;
  localparam logic [1:0]  ADDR_ERR  = 2'h2;
  localparam logic [7:0]  REG_RST   = 8'h00;

  // control fields
  localparam int CTRL_MASTER  = 7;
  localparam int CTRL_SLEEP   = 6;
  localparam int CTRL_CLR_ERR = 2;
  localparam int CTRL_WAKE    = 1;
  localparam int CTRL_START   = 0;

  // status fields
  localparam int ST_IDLE_TO = 6;
  localparam int ST_ERROR   = 2;
  localparam int ST_WAKEUP  = 1;
  localparam int ST_DONE    = 0;

  // error fields
  localparam int ERR_TIMEOUT = 2;

  // ---------------------------------------------------------------
  // wake-up transmit states
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    LSWE_IDLE  = 3'b001,
    LSWE_PULSE = 3'b010,
    LSWE_WAIT  = 3'b100
  } lswe_wake_t;

endpackage

// ### shared/lswe_tmr_if.sv
interface lswe_tmr_if;
  logic restart;
  logic run;
  logic fire;

  modport ctl (output restart, output run, input fire);
  modport tmr (input restart, input run, output fire);
endinterface

// ### logic/lswe_timer.sv
module lswe_timer #(
  parameter logic [lswe_pkg::CNT_W-1:0] LIMIT = lswe_pkg::DETECT_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control
  lswe_tmr_if.tmr  t
);

  logic [lswe_pkg::CNT_W-1:0] cnt_reg;
  logic [lswe_pkg::CNT_W-1:0] cnt_next;
  logic                       fire_reg;
  logic                       fire_next;

  // saturates at the limit so it fires once per restart
  always_comb begin
    cnt_next  = cnt_reg;
    fire_next = 1'b0;
    if (t.restart) begin
      cnt_next = '0;
    end else if (t.run && (cnt_reg != LIMIT)) begin
      cnt_next  = cnt_reg + 1'b1;
      fire_next = (cnt_reg == (LIMIT - 1'b1));
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_reg  <= '0;
      fire_reg <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      fire_reg <= fire_next;
    end
  end

  assign t.fire = fire_reg;

endmodule

// ### logic/lswe_sync.sv
module lswe_sync (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // raw pin
  input  wire logic din,
  // synchronised level and edges
  output logic      q,
  output logic      fall,
  output logic      rise
);

  logic ff1_reg;
  logic ff2_reg;
  logic ff3_reg;
  logic ff1_next;
  logic ff2_next;
  logic ff3_next;

  // edges look at the second and third stage only
  always_comb begin
    ff1_next = din;
    ff2_next = ff1_reg;
    ff3_next = ff2_reg;
  end

  // recessive (high) after reset
  always_ff @(posedge clk) begin
    if (rst) begin
      ff1_reg <= 1'b1;
      ff2_reg <= 1'b1;
      ff3_reg <= 1'b1;
    end else begin
      ff1_reg <= ff1_next;
      ff2_reg <= ff2_next;
      ff3_reg <= ff3_next;
    end
  end

  assign q    = ff2_reg;
  assign fall = ff3_reg & ~ff2_reg;
  assign rise = ~ff3_reg & ff2_reg;

endmodule

// ### logic/lswe_ctrl.sv
// How it works
// - four seconds idle sets flag, interrupts
// - either role can transmit wake-up signal
// - wake request bit starts dominant wake pulse
// - master wake success sets done, interrupts
// - slave: no irq; 150 ms timeout errors
// - timeout sets status bit 2, error bit 2
// - detected wake sets wakeup and done flags
// - any error interrupts and aborts frame
// - clear-error write wipes errors and flag
// - error flag blocks master start, wake
//
// The implementer's own choices: the address map and the strobed register port.
module lswe_ctrl #(
  parameter logic [lswe_pkg::CNT_W-1:0] IDLE_CYCLES  = lswe_pkg::IDLE_CYCLES,
  parameter logic [lswe_pkg::CNT_W-1:0] RESP_CYCLES  = lswe_pkg::RESP_CYCLES,
  parameter logic [lswe_pkg::CNT_W-1:0] PULSE_CYCLES = lswe_pkg::PULSE_CYCLES
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // register port
  input  wire logic [1:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  // lin pin
  input  wire logic        lin_rx,
  output logic             lin_tx,
  // frame engine
  input  wire logic        frame_tx,
  input  wire logic [7:0]  frame_err,
  output logic             msg_start,
  output logic             frame_abort,
  output logic             master_role,
  // interrupt request
  output logic             irq
);

  // ---------------------------------------------------------------
  // bus pin synchroniser
  // ---------------------------------------------------------------
  logic rx_q;
  logic rx_fall;
  logic rx_rise;

  lswe_sync u_rx_sync (
    .clk  (clk),
    .rst  (rst),
    .din  (lin_rx),
    .q    (rx_q),
    .fall (rx_fall),
    .rise (rx_rise)
  );

  // ---------------------------------------------------------------
  // timers
  // ---------------------------------------------------------------
  lswe_tmr_if idle_t ();
  lswe_tmr_if pulse_t ();
  lswe_tmr_if resp_t ();
  lswe_tmr_if det_t ();

  lswe_timer #(.LIMIT(IDLE_CYCLES)) u_idle_tmr (
    .clk (clk),
    .rst (rst),
    .t   (idle_t)
  );

  lswe_timer #(.LIMIT(PULSE_CYCLES)) u_pulse_tmr (
    .clk (clk),
    .rst (rst),
    .t   (pulse_t)
  );

  lswe_timer #(.LIMIT(RESP_CYCLES)) u_resp_tmr (
    .clk (clk),
    .rst (rst),
    .t   (resp_t)
  );

  lswe_timer #(.LIMIT(lswe_pkg::DETECT_CYCLES)) u_det_tmr (
    .clk (clk),
    .rst (rst),
    .t   (det_t)
  );

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  lswe_pkg::lswe_wake_t wake_state_reg;
  lswe_pkg::lswe_wake_t wake_state_next;

  logic       master_reg;
  logic       master_next;
  logic       sleep_reg;
  logic       sleep_next;
  logic       done_reg;
  logic       done_next;
  logic       wakeup_reg;
  logic       wakeup_next;
  logic       error_reg;
  logic       error_next;
  logic       idle_to_reg;
  logic       idle_to_next;
  logic [7:0] err_reg;
  logic [7:0] err_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic       tx_reg;
  logic       tx_next;
  logic       start_reg;
  logic       start_next;
  logic       abort_reg;
  logic       abort_next;

  // decoded strobes and events
  logic       wr_ctrl;
  logic       wr_stat;
  logic       clear_err;
  logic       wake_go;
  logic       wake_ok_master;
  logic       resp_timeout;
  logic [7:0] err_set;
  logic       err_event;

  assign wr_ctrl   = reg_wr && (reg_addr == lswe_pkg::ADDR_CTRL);
  assign wr_stat   = reg_wr && (reg_addr == lswe_pkg::ADDR_STAT);
  assign clear_err = wr_ctrl && reg_wdata[lswe_pkg::CTRL_CLR_ERR];

  // ---------------------------------------------------------------
  // timer control
  // ---------------------------------------------------------------
  // any edge restarts; stopped while asleep so it never refires
  assign idle_t.restart  = rx_fall | rx_rise | sleep_reg;
  assign idle_t.run      = ~sleep_reg;
  assign pulse_t.restart = (wake_state_reg != lswe_pkg::LSWE_PULSE);
  assign pulse_t.run     = 1'b1;
  assign resp_t.restart  = (wake_state_reg != lswe_pkg::LSWE_WAIT);
  assign resp_t.run      = 1'b1;
  // wake detect only when asleep, so a break is never taken for one
  assign det_t.restart   = rx_q | ~sleep_reg |
                           (wake_state_reg != lswe_pkg::LSWE_IDLE);
  assign det_t.run       = 1'b1;

  // ---------------------------------------------------------------
  // wake-up transmit sequence
  // ---------------------------------------------------------------
  // refused silently while an error is pending or a wake sequence (pulse or response wait) is busy
  assign wake_go = wr_ctrl && reg_wdata[lswe_pkg::CTRL_WAKE] &&
                   (wake_state_reg == lswe_pkg::LSWE_IDLE) &&
                   !error_reg;

  always_comb begin
    wake_state_next = wake_state_reg;
    wake_ok_master  = 1'b0;
    resp_timeout    = 1'b0;
    unique case (wake_state_reg)
      lswe_pkg::LSWE_IDLE: begin
        if (wake_go) begin
          wake_state_next = lswe_pkg::LSWE_PULSE;
        end
      end
      lswe_pkg::LSWE_PULSE: begin
        if (pulse_t.fire) begin
          if (master_reg) begin
            wake_ok_master  = 1'b1;
            wake_state_next = lswe_pkg::LSWE_IDLE;
          end else begin
            wake_state_next = lswe_pkg::LSWE_WAIT;
          end
        end
      end
      lswe_pkg::LSWE_WAIT: begin
        // a header edge from the master is the response
        if (rx_fall) begin
          wake_state_next = lswe_pkg::LSWE_IDLE;
        end else if (resp_t.fire) begin
          resp_timeout    = 1'b1;
          wake_state_next = lswe_pkg::LSWE_IDLE;
        end
      end
      default: begin
        wake_state_next = lswe_pkg::LSWE_IDLE;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // error handling
  // ---------------------------------------------------------------
  always_comb begin
    err_set = frame_err;
    err_set[lswe_pkg::ERR_TIMEOUT] = frame_err[lswe_pkg::ERR_TIMEOUT] |
                                     resp_timeout;
    err_event = |err_set;
    // set wins over a clear in the same cycle
    err_next = (clear_err ? lswe_pkg::REG_RST : err_reg) | err_set;
    error_next = (error_reg & ~clear_err) | err_event;
    abort_next = err_event;
  end

  // ---------------------------------------------------------------
  // control and status flags
  // ---------------------------------------------------------------
  always_comb begin
    master_next = master_reg;
    sleep_next  = sleep_reg;
    if (wr_ctrl) begin
      master_next = reg_wdata[lswe_pkg::CTRL_MASTER];
      sleep_next  = reg_wdata[lswe_pkg::CTRL_SLEEP];
    end
    // status bits are write-one-to-clear; error only via clear bit
    done_next = (done_reg & ~(wr_stat & reg_wdata[lswe_pkg::ST_DONE])) |
                wake_ok_master | det_t.fire;
    wakeup_next = (wakeup_reg &
                   ~(wr_stat & reg_wdata[lswe_pkg::ST_WAKEUP])) |
                  det_t.fire;
    idle_to_next = (idle_to_reg &
                    ~(wr_stat & reg_wdata[lswe_pkg::ST_IDLE_TO])) |
                   idle_t.fire;
    start_next = wr_ctrl && reg_wdata[lswe_pkg::CTRL_START] &&
                 master_reg && !error_reg;
  end

  // ---------------------------------------------------------------
  // pin drive and read-back
  // ---------------------------------------------------------------
  always_comb begin
    // dominant pulse overrides the frame engine's own drive
    tx_next    = frame_tx & (wake_state_reg != lswe_pkg::LSWE_PULSE);
    rdata_next = lswe_pkg::REG_RST;
    if (reg_rd) begin
      unique case (reg_addr)
        lswe_pkg::ADDR_CTRL: begin
          rdata_next[lswe_pkg::CTRL_MASTER] = master_reg;
          rdata_next[lswe_pkg::CTRL_SLEEP]  = sleep_reg;
          rdata_next[lswe_pkg::CTRL_WAKE]   =
            (wake_state_reg != lswe_pkg::LSWE_IDLE);
        end
        lswe_pkg::ADDR_STAT: begin
          rdata_next[lswe_pkg::ST_IDLE_TO] = idle_to_reg;
          rdata_next[lswe_pkg::ST_ERROR]   = error_reg;
          rdata_next[lswe_pkg::ST_WAKEUP]  = wakeup_reg;
          rdata_next[lswe_pkg::ST_DONE]    = done_reg;
        end
        lswe_pkg::ADDR_ERR: begin
          rdata_next = err_reg;
        end
        default: begin
          rdata_next = lswe_pkg::REG_RST;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      wake_state_reg <= lswe_pkg::LSWE_IDLE;
      master_reg     <= 1'b0;
      sleep_reg      <= 1'b0;
      done_reg       <= 1'b0;
      wakeup_reg     <= 1'b0;
      error_reg      <= 1'b0;
      idle_to_reg    <= 1'b0;
      err_reg        <= lswe_pkg::REG_RST;
      rdata_reg      <= lswe_pkg::REG_RST;
      tx_reg         <= 1'b1;
      start_reg      <= 1'b0;
      abort_reg      <= 1'b0;
    end else begin
      wake_state_reg <= wake_state_next;
      master_reg     <= master_next;
      sleep_reg      <= sleep_next;
      done_reg       <= done_next;
      wakeup_reg     <= wakeup_next;
      error_reg      <= error_next;
      idle_to_reg    <= idle_to_next;
      err_reg        <= err_next;
      rdata_reg      <= rdata_next;
      tx_reg         <= tx_next;
      start_reg      <= start_next;
      abort_reg      <= abort_next;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign reg_rdata   = rdata_reg;
  assign lin_tx      = tx_reg;
  assign msg_start   = start_reg;
  assign frame_abort = abort_reg;
  assign master_role = master_reg;
  // level, held by the sticky flags themselves
  assign irq = done_reg | wakeup_reg | error_reg | idle_to_reg;

endmodule

// ### verif/lswe_ctrl_props.sv
module lswe_ctrl_props (
  // clock and reset
  input wire logic       clk,
  input wire logic       rst,
  // register port
  input wire logic [1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  // lin pin and frame engine
  input wire logic       lin_rx,
  input wire logic       lin_tx,
  input wire logic       frame_tx,
  input wire logic [7:0] frame_err,
  input wire logic       msg_start,
  input wire logic       frame_abort,
  input wire logic       master_role,
  input wire logic       irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  chk_rdata_slot: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data outside its slot");
  chk_abort_err: assert property (frame_err != 8'h00 |=> frame_abort)
    else $error("error without abort");
  chk_abort_irq: assert property (frame_abort |-> irq)
    else $error("abort without irq");
  chk_start_role: assert property (msg_start |-> $past(master_role))
    else $error("start outside master role");
  chk_irq_hold: assert property (irq && !reg_wr |=> irq)
    else $error("irq dropped without a write");
  chk_wake_len: assert property (
    $fell(lin_tx) && $past(frame_tx) |-> !lin_tx [*8])
    else $error("wake pulse too short");
  chk_tx_follow: assert property (!$past(frame_tx) |-> !lin_tx)
    else $error("frame bit not driven");
  chk_role_load: assert property (
    reg_wr && reg_addr == 2'h0 |=> master_role == $past(reg_wdata[7]))
    else $error("role bit not loaded");

  cover property (frame_abort);
  cover property ($fell(lin_tx) && $past(frame_tx));
  cover property (msg_start);
endmodule

bind lswe_ctrl lswe_ctrl_props u_lswe_ctrl_props (
  .clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .lin_rx, .lin_tx, .frame_tx, .frame_err, .msg_start, .frame_abort,
  .master_role, .irq
);

// ### verif/lswe_bus_node.sv
module lswe_bus_node (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // bus side
  input  wire logic dut_tx,
  output logic      bus,
  // bench control
  input  wire logic resp_en,
  input  wire logic wake_go
);
  timeunit 1ns;
  timeprecision 1ps;
  int low_cnt;
  int resp_cnt;
  int tx_low;

  always_ff @(posedge clk) begin
    if (rst) begin
      low_cnt  <= 0;
      resp_cnt <= 0;
      tx_low   <= 0;
    end else begin
      tx_low <= dut_tx ? 0 : tx_low + 1;
      if (wake_go) begin
        low_cnt <= 3100;
      end else if (resp_cnt == 1) begin
        low_cnt <= 4;
      end else if (low_cnt > 0) begin
        low_cnt <= low_cnt - 1;
      end
      // only a long dominant run counts as a wake pulse to answer
      if (dut_tx && tx_low >= 8 && resp_en) begin
        resp_cnt <= 10;
      end else if (resp_cnt > 0) begin
        resp_cnt <= resp_cnt - 1;
      end
    end
  end

  // pull-up: a released line reads recessive
  assign bus = dut_tx & (low_cnt == 0);
endmodule

// ### verif/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [1:0] CT = lswe_pkg::ADDR_CTRL;
  localparam logic [1:0] ST = lswe_pkg::ADDR_STAT;
  localparam logic [1:0] ER = lswe_pkg::ADDR_ERR;
  localparam logic [26:0] PULSE_LEN = 27'h0000014;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic [1:0] reg_addr = 2'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] frame_err = 8'h00;
  logic [7:0] reg_rdata;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic       frame_tx = 1'b1;
  logic       resp_en = 1'b0;
  logic       wake_go = 1'b0;
  logic       lin_tx, lin_rx, msg_start, frame_abort, master_role, irq;
  int         mismatches = 0;
  int         comparisons = 0;

  always #25 clk = ~clk;

  lswe_ctrl #(
    .IDLE_CYCLES (27'h00000C8),
    .RESP_CYCLES (27'h0000064),
    .PULSE_CYCLES(PULSE_LEN)
  ) u_lswe_ctrl (
    .clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .lin_rx, .lin_tx, .frame_tx, .frame_err, .msg_start, .frame_abort,
    .master_role, .irq
  );
  lswe_bus_node u_lswe_bus_node (
    .clk, .rst, .dut_tx(lin_tx), .bus(lin_rx), .resp_en, .wake_go
  );

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [1:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 check(reg_rdata, exp);
  endtask

  function automatic logic [7:0] st(bit i, bit e, bit w, bit d);
    st = 8'h00;
    st[lswe_pkg::ST_IDLE_TO] = i;
    st[lswe_pkg::ST_ERROR]   = e;
    st[lswe_pkg::ST_WAKEUP]  = w;
    st[lswe_pkg::ST_DONE]    = d;
  endfunction

  task automatic results;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // watchdog: whole run is about 4000 cycles
  initial begin
    #1_000_000;
    mismatches++;
    results();
  end

  initial begin
    logic [7:0] e;
    int         n;
    void'($urandom(32'h7A4D));
    cyc(3);
    rst <= 1'b0;
    rd(CT, 8'h00);
    rd(ER, 8'h00);
    wr(2'h3, 8'hFF);
    rd(2'h3, 8'h00);
    // ---------------------------------------------------------------
    // idle timeout, then sleep
    // ---------------------------------------------------------------
    cyc(220);
    rd(ST, st(1, 0, 0, 0));
    check({7'h00, irq}, 8'h01);
    wr(ST, 8'h40);
    check({7'h00, irq}, 8'h00);
    wr(CT, 8'hC0);
    check({7'h00, master_role}, 8'h01);
    // ---------------------------------------------------------------
    // errors block wake and start until cleared
    // ---------------------------------------------------------------
    repeat (3) begin
      e = 8'($urandom_range(255, 1));
      @(posedge clk);
      frame_err <= e;
      frame_tx  <= 1'($urandom);
      @(posedge clk);
      frame_err <= 8'h00;
      frame_tx  <= 1'b1;
      #1 check({7'h00, frame_abort}, 8'h01);
      rd(ER, e);
      rd(ST, st(0, 1, 0, 0));
      wr(CT, 8'hC3);
      check({7'h00, msg_start}, 8'h00);
      rd(CT, 8'hC0);
      wr(CT, 8'hC4);
      rd(ER, 8'h00);
      rd(ST, 8'h00);
    end
    // corner: new error in the cycle of the clear, set wins
    @(posedge clk);
    frame_err <= 8'h01;
    reg_addr  <= CT;
    reg_wdata <= 8'hC4;
    reg_wr    <= 1'b1;
    @(posedge clk);
    frame_err <= 8'h00;
    reg_wr    <= 1'b0;
    rd(ST, st(0, 1, 0, 0));
    rd(ER, 8'h01);
    wr(CT, 8'hC4);
    rd(ST, 8'h00);
    // ---------------------------------------------------------------
    // master wake pulse and frame start
    // ---------------------------------------------------------------
    n = 0;
    wr(CT, 8'hC2);
    for (int i = 0; i < 100; i++) begin
      @(posedge clk);
      #1 if (lin_tx === 1'b0) n++;
    end
    // registered fire: the drive holds through the firing cycle too
    check(n[7:0], 8'(PULSE_LEN + 27'h0000001));
    rd(ST, st(0, 0, 0, 1));
    wr(ST, 8'h01);
    wr(CT, 8'hC1);
    check({7'h00, msg_start}, 8'h01);
    // an ordinary frame bit goes out through the normal path
    @(posedge clk);
    frame_tx <= 1'b0;
    @(posedge clk);
    frame_tx <= 1'b1;
    #1 check({7'h00, lin_tx}, 8'h00);
    // ---------------------------------------------------------------
    // slave wake: answered, then unanswered
    // ---------------------------------------------------------------
    resp_en <= 1'b1;
    wr(CT, 8'h42);
    cyc(200);
    rd(ST, 8'h00);
    check({7'h00, irq}, 8'h00);
    resp_en <= 1'b0;
    wr(CT, 8'h42);
    cyc(50);
    rd(CT, 8'h42);
    cyc(100);
    rd(ST, st(0, 1, 0, 0));
    rd(ER, 8'h04);
    rd(CT, 8'h40);
    check({7'h00, irq}, 8'h01);
    wr(CT, 8'h44);
    // ---------------------------------------------------------------
    // wake from a far node while asleep
    // ---------------------------------------------------------------
    @(posedge clk);
    wake_go <= 1'b1;
    @(posedge clk);
    wake_go <= 1'b0;
    cyc(3150);
    rd(ST, st(0, 0, 1, 1));
    wr(CT, 8'h00);
    wr(ST, 8'h03);
    rd(ST, 8'h00);
    rd(CT, 8'h00);
    results();
  end
endmodule
